/* ira_defines.svh */
// Constants for the indirect RAM access register bank.
// Assumes inclusion by bare name from the package.
`ifndef IRA_DEFINES_SVH
`define IRA_DEFINES_SVH

// ==========================================================
// Register offsets
`define IRA_OFS_MEM_TEST_CTRL   8'h1D
`define IRA_OFS_IND_ACC_CTRL    8'h1E
`define IRA_OFS_IND_DATA_WIN    8'h1F
`define IRA_OFS_ALIAS_FIRST     8'h20
`define IRA_OFS_ALIAS_LAST      8'h2E

// ==========================================================
// Field positions
`define IRA_MTC_WADDR_MSB       9
`define IRA_MTC_RSEL_LSB        10
`define IRA_MTC_RSEL_MSB        12
`define IRA_MTC_LUMA_BIT        13
`define IRA_MTC_OBUF_BIT        14
`define IRA_MTC_WEN_BIT         15
`define IRA_IAC_ADDR_MSB        10
`define IRA_IAC_BURST_BIT       13
`define IRA_IAC_WEN_BIT         14
`define IRA_IAC_AINC_BIT        15

// ==========================================================
// Reset values and counts
`define IRA_RST_VAL             16'h0000
`define IRA_RAM_LAST_WORD       10'h31F
`define IRA_MAX_BURST           16
`define IRA_MAX_BURST_CYCLES    128

`endif

/* ira_pkg.sv */
// Types for the indirect RAM access register bank.
// Assumes ira_defines.svh is on the include path.
package ira_pkg;
  `include "ira_defines.svh"

  // ==========================================================
  // Host register port
  typedef struct packed {
    logic [7:0]  addr;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
  } ira_host_req_s;

  // ==========================================================
  // Indirect register target port
  typedef struct packed {
    logic [10:0] addr;
    logic        we;
    logic        re;
    logic [15:0] wdata;
  } ira_ind_req_s;

  // ==========================================================
  // Test RAM port, write goes to all seventeen RAMs
  typedef struct packed {
    logic [9:0]  addr;
    logic        we;
    logic        re;
    logic [15:0] wdata;
  } ira_tram_req_s;

  // ==========================================================
  // Whole module state
  typedef struct packed {
    logic [15:0] mtc;
    logic [15:0] iac;
    logic [15:0] win;
    logic [15:0] rdata;
    logic        rvalid;
    logic        wr_pend;
    logic        wr_test;
  } ira_state_s;
endpackage

/* ira_indirect_ram_access.sv */
// Indirect access port to internal registers and test RAMs.
// Assumes a serial-interface decoder drives the host port synchronously to clk,
// and that targets return read data combinationally in the strobe cycle.
`timescale 1ns/1ps

// Contract
// - The test control word address, bits 9:0, picks one of the 800 words of the test RAM.
// - The test word address steps by one on each data window write in test write or read in test read.
// - Test control bits 12:10 choose one of the eight RAMs of the selected bank, 000 first to 111 eighth.
// - Test control bit 13 picks the luminance bank when one and the chrominance bank when zero.
// - Test control bit 14 makes test reads come from the output buffer RAM and has no effect on writes.
// - With test bit 15 set, a window write copies the window into the addressed word of all seventeen RAMs.
// - With test bit 15 clear, a window access does a test read into the window; test cycles occur only on window access.
// - The access control register holds an 11-bit indirect address in bits 10:0.
// - Bit 13 makes the decoder treat the window in burst mode, and the host keeps bursts within 16 words or 128 cycles.
// - With bit 14 set a window write goes to the addressed location unless auto-increment is set; clear, it reads.
// - With bit 15 set the indirect address steps by one after every window read or write outside test mode.
// - A window access acts as that access on the addressed target, and auto-increment makes a burst; writes need bit 14 set and 15 clear, reads bit 14 clear.
// - The window reaches the indirect registers normally and the test RAMs when the test mode flag is one.
// - During a burst, addresses 0x20 to 0x2E alias the data window.
module ira_indirect_ram_access (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire ira_pkg::ira_host_req_s host_req,
  output logic [15:0]                 host_rdata,
  output logic                        host_rvalid,
  output logic                        host_busy,
  input  wire logic                   memory_test_mode_flag,
  output ira_pkg::ira_ind_req_s       ind_req,
  input  wire logic [15:0]            ind_rdata,
  output ira_pkg::ira_tram_req_s      tram_req,
  input  wire logic [15:0][15:0]      bank_rdata,
  input  wire logic [15:0]            obuf_rdata
);
  import ira_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic [9:0] next_word(input logic [9:0] a);
    next_word = (a >= `IRA_RAM_LAST_WORD) ? 10'h000 : 10'(a + 10'h001);
  endfunction

  // Indirect address rolls over at 11 bits, no limit of its own
  function automatic logic [10:0] next_iaddr(input logic [10:0] a);
    next_iaddr = 11'(a + 11'h001);
  endfunction

  function automatic logic is_window(input logic [7:0] a, input logic burst);
    is_window = (a == `IRA_OFS_IND_DATA_WIN) ||
                (burst && a >= `IRA_OFS_ALIAS_FIRST && a <= `IRA_OFS_ALIAS_LAST);
  endfunction

  ira_state_s  q;
  ira_state_s  d;
  logic        win_hit;
  logic        test_mode;
  logic [3:0]  ram_idx;
  logic [15:0] test_rd;
  logic [9:0]  waddr;
  logic [10:0] iaddr;

  // ==========================================================
  // Decode and read paths
  assign waddr     = q.mtc[`IRA_MTC_WADDR_MSB:0];
  assign iaddr     = q.iac[`IRA_IAC_ADDR_MSB:0];
  assign test_mode = memory_test_mode_flag;
  assign win_hit   = is_window(host_req.addr, q.iac[`IRA_IAC_BURST_BIT]);
  assign ram_idx   = {q.mtc[`IRA_MTC_LUMA_BIT], q.mtc[`IRA_MTC_RSEL_MSB:`IRA_MTC_RSEL_LSB]};
  assign test_rd   = q.mtc[`IRA_MTC_OBUF_BIT] ? obuf_rdata : bank_rdata[ram_idx];

  // Writes go out one cycle after they land in the window, so target data
  // comes from a flop; the cost is one busy cycle after each window write that goes out to a target.
  assign host_busy   = q.wr_pend;
  assign host_rdata  = q.rdata;
  assign host_rvalid = q.rvalid;

  always_comb begin
    ind_req.addr  = iaddr;
    ind_req.wdata = q.win;
    ind_req.we    = q.wr_pend && !q.wr_test;
    ind_req.re    = !q.wr_pend && host_req.rd && !host_req.wr && win_hit && !test_mode
                    && !q.iac[`IRA_IAC_WEN_BIT];
    tram_req.addr  = waddr;
    tram_req.wdata = q.win;
    tram_req.we    = q.wr_pend && q.wr_test;
    tram_req.re    = !q.wr_pend && win_hit && test_mode && !q.mtc[`IRA_MTC_WEN_BIT]
                     && (host_req.rd || host_req.wr);
  end

  // ==========================================================
  // Next state
  always_comb begin
    d        = q;
    d.rvalid = 1'b0;
    d.wr_pend = 1'b0;
    if (q.wr_pend) begin
      if (q.wr_test) begin
        d.mtc[`IRA_MTC_WADDR_MSB:0] = next_word(waddr);
      end else if (q.iac[`IRA_IAC_AINC_BIT]) begin
        d.iac[`IRA_IAC_ADDR_MSB:0] = next_iaddr(iaddr);
      end
    end else if (host_req.wr) begin
      if (win_hit) begin
        if (test_mode && !q.mtc[`IRA_MTC_WEN_BIT]) begin
          d.win = test_rd;
          d.mtc[`IRA_MTC_WADDR_MSB:0] = next_word(waddr);
        end else begin
          d.win = host_req.wdata;
          d.wr_test = test_mode;
          // Literal reading: auto-increment suppresses the indirect write
          if (test_mode || (q.iac[`IRA_IAC_WEN_BIT] && !q.iac[`IRA_IAC_AINC_BIT])) begin
            d.wr_pend = 1'b1;
          end else if (q.iac[`IRA_IAC_AINC_BIT]) begin
            d.iac[`IRA_IAC_ADDR_MSB:0] = next_iaddr(iaddr);
          end
        end
      end else if (host_req.addr == `IRA_OFS_MEM_TEST_CTRL) begin
        d.mtc = host_req.wdata;
      end else if (host_req.addr == `IRA_OFS_IND_ACC_CTRL) begin
        d.iac = host_req.wdata;
      end
    end else if (host_req.rd) begin
      d.rvalid = 1'b1;
      d.rdata  = 16'h0000;
      if (win_hit) begin
        if (test_mode) begin
          if (!q.mtc[`IRA_MTC_WEN_BIT]) begin
            d.win   = test_rd;
            d.rdata = test_rd;
            d.mtc[`IRA_MTC_WADDR_MSB:0] = next_word(waddr);
          end else begin
            d.rdata = q.win;
          end
        end else begin
          if (!q.iac[`IRA_IAC_WEN_BIT]) begin
            d.win   = ind_rdata;
            d.rdata = ind_rdata;
          end else begin
            d.rdata = q.win;
          end
          if (q.iac[`IRA_IAC_AINC_BIT]) begin
            d.iac[`IRA_IAC_ADDR_MSB:0] = next_iaddr(iaddr);
          end
        end
      end else if (host_req.addr == `IRA_OFS_MEM_TEST_CTRL) begin
        d.rdata = q.mtc;
      end else if (host_req.addr == `IRA_OFS_IND_ACC_CTRL) begin
        d.rdata = q.iac;
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

/* ira_chk.sv */
// Assertions for the indirect access port.
// Assumes binding to ira_indirect_ram_access, one clock domain.
`timescale 1ns/1ps
module ira_chk (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire ira_pkg::ira_host_req_s host_req,
  input wire logic                   host_rvalid,
  input wire logic                   host_busy,
  input wire logic                   memory_test_mode_flag,
  input wire ira_pkg::ira_ind_req_s  ind_req,
  input wire ira_pkg::ira_tram_req_s tram_req
);
  import ira_pkg::*;
  // ==========================================================
  // Port relations
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire take_wr = host_req.wr && !host_busy;
  // Expected next test word, wrapping after the last word
  wire [9:0] tram_next = (tram_req.addr >= 10'h31F) ? 10'h000 : 10'(tram_req.addr + 10'h001);
  rd_answer_a: assert property (
    host_req.rd && !host_req.wr && !host_busy |=> host_rvalid) else $error("read not answered");
  busy_pulse_a: assert property (
    host_busy |=> !host_busy) else $error("busy too long");
  ind_wr_data_a: assert property (
    ind_req.we |-> host_busy && ind_req.wdata == $past(host_req.wdata)) else $error("bad target write");
  tram_wr_data_a: assert property (
    tram_req.we |-> host_busy && tram_req.wdata == $past(host_req.wdata)) else $error("bad ram write");
  tram_wr_step_a: assert property (
    tram_req.we |=> tram_req.addr == $past(tram_next)) else $error("bad write step");
  tram_rd_step_a: assert property (
    tram_req.re && !host_busy |=> tram_req.addr == $past(tram_next)) else $error("bad read step");
  iac_addr_a: assert property (
    take_wr && host_req.addr == 8'h1E |=> ind_req.addr == $past(host_req.wdata[10:0])) else $error("bad address");
  ind_route_a: assert property (
    host_req.rd && !host_req.wr && !host_busy && host_req.addr == 8'h1F
    |-> (memory_test_mode_flag ? !ind_req.re : !tram_req.re)) else $error("bad route");
endmodule

bind ira_indirect_ram_access ira_chk chk_u (.clk, .rst, .host_req, .host_rvalid, .host_busy,
  .memory_test_mode_flag, .ind_req, .tram_req);

/* ira_tgt_model.sv */
// Far-side targets: indirect registers and seventeen test RAMs.
// Assumes reads answered combinationally in the strobe cycle.
`timescale 1ns/1ps
module ira_tgt_model (
  input  wire logic                   clk,
  input  wire ira_pkg::ira_ind_req_s  ind_req,
  output logic [15:0]                 ind_rdata,
  input  wire ira_pkg::ira_tram_req_s tram_req,
  output logic [15:0][15:0]           bank_rdata,
  output logic [15:0]                 obuf_rdata
);
  import ira_pkg::*;
  logic [15:0] regs [2048];
  logic [15:0] ram  [17][800];
  initial begin
    for (int i = 0; i < 2048; i++) regs[i] = 16'(i) ^ 16'h5A5A;
    for (int r = 0; r < 17; r++) for (int w = 0; w < 800; w++) ram[r][w] = 16'(r * 16'h0321) ^ 16'(w);
  end
  always @(posedge clk) begin
    if (ind_req.we) regs[ind_req.addr] <= ind_req.wdata;
    if (tram_req.we) for (int r = 0; r < 17; r++) ram[r][tram_req.addr] <= tram_req.wdata;
  end
  // Unstrobed lines show garbage, not the stored word
  always_comb begin
    ind_rdata = ind_req.re ? regs[ind_req.addr] : ~regs[ind_req.addr];
    for (int r = 0; r < 16; r++) bank_rdata[r] = tram_req.re ? ram[r][tram_req.addr] : ~ram[r][tram_req.addr];
    obuf_rdata = tram_req.re ? ram[16][tram_req.addr] : ~ram[16][tram_req.addr];
  end
endmodule

/* ira_indirect_ram_access_tb_top.sv */
// Self-checking bench for the indirect access port.
// Assumes ira_tgt_model stands in for the targets.
`timescale 1ns/1ps
module ira_indirect_ram_access_tb_top;
  import ira_pkg::*;
  logic             clk = 0, rst = 1, flag = 0, rvalid, busy;
  ira_host_req_s    hreq = '0;
  ira_ind_req_s     ireq;
  ira_tram_req_s    treq;
  logic [15:0]      rdata, ird, obd, v, d;
  logic [15:0][15:0] bkd;
  logic [10:0]      a;
  logic [9:0]       w;
  int               seed = 20334, miscompares = 0, n_checks = 0, cyc = 0;
  always #2.5 clk = ~clk;
  ira_indirect_ram_access dut_u (.clk(clk), .rst(rst), .host_req(hreq), .host_rdata(rdata), .host_rvalid(rvalid),
    .host_busy(busy), .memory_test_mode_flag(flag), .ind_req(ireq), .ind_rdata(ird), .tram_req(treq),
    .bank_rdata(bkd), .obuf_rdata(obd));
  ira_tgt_model tgt_u (.clk(clk), .ind_req(ireq), .ind_rdata(ird), .tram_req(treq), .bank_rdata(bkd),
    .obuf_rdata(obd));
  // ==========================================================
  // Helpers
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [15:0] reg_init(logic [10:0] x);
    return 16'(x) ^ 16'h5A5A;
  endfunction
  function automatic logic [15:0] ram_init(int r, logic [9:0] x);
    return 16'(r * 16'h0321) ^ 16'(x);
  endfunction
  // Idle cycle after each access keeps clear of the busy cycle
  task automatic wr(logic [7:0] ad, logic [15:0] dt);
    hreq = '{ad, 1'b1, 1'b0, dt};
    @(posedge clk) #1 hreq.wr = 0;
    @(posedge clk) #1;
  endtask
  task automatic rd(logic [7:0] ad);
    hreq = '{ad, 1'b0, 1'b1, 16'h0000};
    @(posedge clk) #1 hreq.rd = 0;
    v = rvalid ? rdata : 'x;
    @(posedge clk) #1;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) if (++cyc == 2000) begin
    miscompares++;
    conclude();
  end
  // ==========================================================
  // Scenarios
  initial begin
    repeat (20) @(posedge clk);
    #1 rst = 0;
    for (int r = 0; r < 3; r++) begin
      rd(r == 2 ? 8'h20 : 8'h1D + 8'(r));
      chk("reset", 16'h0000, v);
    end
    a = 11'($random(seed));
    d = 16'($random(seed));
    wr(8'h1E, 16'h4000 | 16'(a));
    wr(8'h1F, d);
    wr(8'h1E, 16'(a));
    rd(8'h1F);
    chk("ind write", d, v);
    wr(8'h1E, 16'hA000 | 16'(11'(a + 11'h001)));
    for (int k = 0; k < 4; k++) begin
      rd(k[0] ? 8'h21 + 8'(k) : 8'h1F);
      chk("burst", reg_init(11'(a + 11'(k + 1))), v);
    end
    rd(8'h1E);
    chk("ind addr", 16'hA000 | 16'(11'(a + 11'h005)), v);
    wr(8'h1E, 16'hC000 | 16'(11'(a + 11'h008)));
    wr(8'h1F, ~d);
    rd(8'h1F);
    chk("win hold", ~d, v);
    rd(8'h1E);
    chk("ainc", 16'hC000 | 16'(11'(a + 11'h00A)), v);
    wr(8'h1E, 16'(11'(a + 11'h008)));
    rd(8'h1F);
    chk("no write", reg_init(11'(a + 11'h008)), v);
    flag = 1;
    w = 10'($unsigned($random(seed)) % 797);
    for (int i = 0; i < 17; i++) begin
      wr(8'h1D, (i == 16 ? 16'h4000 : 16'(i << 10)) | 16'(w));
      rd(8'h1F);
      chk("test read", ram_init(i, w), v);
    end
    rd(8'h1D);
    chk("test addr", 16'h4000 | 16'(w + 10'h001), v);
    wr(8'h1D, 16'hC31D);
    for (int k = 0; k < 3; k++) wr(8'h1F, d ^ 16'(k));
    rd(8'h1D);
    chk("wrap", 16'hC000, v);
    // Read raised in the busy cycle must be dropped
    hreq = '{8'h1F, 1'b1, 1'b0, d};
    @(posedge clk) #1 hreq = '{8'h1D, 1'b0, 1'b1, 16'h0000};
    chk("busy", 16'h0001, 16'(busy));
    @(posedge clk) #1 hreq.rd = 0;
    chk("refused", 16'h0000, 16'(rvalid));
    @(posedge clk) #1;
    wr(8'h1D, 16'h0000);
    rd(8'h1F);
    chk("busy write", d, v);
    wr(8'h1D, 16'h231E);
    rd(8'h1F);
    chk("test write", d ^ 16'h0001, v);
    rst = 1;
    @(posedge clk) #1 rst = 0;
    for (int r = 0; r < 2; r++) begin
      rd(8'h1D + 8'(r));
      chk("mid reset", 16'h0000, v);
    end
    conclude();
  end
endmodule
